// ### logic/cmp_ctrl_cfg.svh
`ifndef CMP_CTRL_CFG_SVH
`define CMP_CTRL_CFG_SVH
// Printed offsets are register indices; byte address is four times the index
`define CMP_IDX_ONE_CTRL 12'h119
`define CMP_IDX_TWO_AUX 12'h11b
`define CMP_IDX_IRQ_STATUS 12'h120
`define CMP_IDX_IRQ_MASK 12'h121
`define CMP_ONE_ENABLE_BIT 7
`define CMP_ONE_RESULT_BIT 6
`define CMP_ONE_PIN_EN_BIT 5
`define CMP_ONE_INVERT_BIT 4
`define CMP_ONE_SPEED_BIT 3
`define CMP_ONE_REF_BIT 2
`define CMP_ONE_CHAN_LSB 0
`define CMP_MIRROR_ONE_BIT 7
`define CMP_MIRROR_TWO_BIT 6
`define CMP_TWO_SYNC_BIT 0
`define CMP_ONE_CTRL_RESET 8'h00
`define CMP_TWO_AUX_RESET 8'h00
`define CMP_IRQ_MASK_RESET 2'h0
`define CMP_ONE_CTRL_WMASK 8'hbf
`endif

// ### logic/cmp_ctrl_pkg.sv
package cmp_ctrl_pkg;
    typedef enum logic [1:0] {
        CHAN_AN4 = 2'b00,
        CHAN_AN5 = 2'b01,
        CHAN_AN6 = 2'b10,
        CHAN_AN7 = 2'b11
    } chan_sel_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b10
    } bus_phase_t;
endpackage : cmp_ctrl_pkg

// ### logic/cmp_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module cmp_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : cmp_sync2
`default_nettype wire

// ### logic/cmp_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "cmp_ctrl_cfg.svh"
module cmp_ctrl #(
    parameter int ADDR_W = 12
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    input wire logic I_CMP_ONE_RAW,
    input wire logic I_CMP_TWO_RAW,
    input wire logic I_TIMER_ONE_CLK,
    output logic O_CMP_ONE_ENABLE,
    output logic [1:0] O_CMP_ONE_CHANNEL_SELECT,
    output logic O_CMP_ONE_REF_SELECT,
    output logic O_CMP_ONE_SPEED,
    output logic O_CMP_ONE_PIN,
    output logic O_CMP_ONE_PIN_OE,
    output logic O_CMP_TWO_RESULT,
    output logic O_IRQ
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [2:0] raw_s;
    logic one_s;
    logic two_s;
    logic tclk_s;

    cmp_sync2 #(.WIDTH(3)) u_sync (
        .i_clk(I_SYS_CLK),
        .i_resetn(I_RESETN),
        .i_async({I_TIMER_ONE_CLK, I_CMP_TWO_RAW, I_CMP_ONE_RAW}),
        .o_sync(raw_s)
    );
    assign one_s = raw_s[0];
    assign two_s = raw_s[1];
    assign tclk_s = raw_s[2];

    // ****************************************
    // Bus address phase capture
    // ****************************************
    cmp_ctrl_pkg::bus_phase_t phase_q;
    logic [ADDR_W-1:0] idx_q;
    logic [7:0] one_ctrl_q;
    logic sync_sel_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic res_one_q;
    logic res_two_q;
    logic prev_one_q;
    logic prev_two_q;
    logic tclk_prev_q;
    logic res_one_now;
    logic res_two_next;
    logic [1:0] change_ev;
    logic rd_status;
    logic wr_ctrl;
    logic wr_aux;
    logic wr_mask;

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            phase_q <= cmp_ctrl_pkg::BUS_IDLE;
            idx_q <= '0;
        end else if (I_HREADY) begin
            if (I_HSEL && I_HTRANS[1]) begin
                phase_q <= I_HWRITE ? cmp_ctrl_pkg::BUS_WRITE : cmp_ctrl_pkg::BUS_READ;
                idx_q <= I_HADDR[ADDR_W+1:2];
            end else begin
                phase_q <= cmp_ctrl_pkg::BUS_IDLE;
            end
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_HREADYOUT <= 1'b0;
            O_HRESP <= 1'b0;
        end else begin
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end
    end

    assign wr_ctrl = (phase_q == cmp_ctrl_pkg::BUS_WRITE) && (idx_q == ADDR_W'(`CMP_IDX_ONE_CTRL));
    assign wr_aux = (phase_q == cmp_ctrl_pkg::BUS_WRITE) && (idx_q == ADDR_W'(`CMP_IDX_TWO_AUX));
    assign wr_mask = (phase_q == cmp_ctrl_pkg::BUS_WRITE) && (idx_q == ADDR_W'(`CMP_IDX_IRQ_MASK));
    assign rd_status = (phase_q == cmp_ctrl_pkg::BUS_READ) && (idx_q == ADDR_W'(`CMP_IDX_IRQ_STATUS));

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            one_ctrl_q <= `CMP_ONE_CTRL_RESET;
        end else if (wr_ctrl) begin
            // Result flag position is masked off so writes cannot touch it
            one_ctrl_q <= I_HWDATA[7:0] & `CMP_ONE_CTRL_WMASK;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sync_sel_q <= 1'(`CMP_TWO_AUX_RESET >> `CMP_TWO_SYNC_BIT);
        end else if (wr_aux) begin
            sync_sel_q <= I_HWDATA[`CMP_TWO_SYNC_BIT];
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            mask_q <= `CMP_IRQ_MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= I_HWDATA[1:0];
        end
    end

    // ****************************************
    // Comparator results
    // ****************************************
    // Disabled comparator reads as zero rather than a stale result
    always_comb begin
        res_one_now = 1'b0;
        if (one_ctrl_q[`CMP_ONE_ENABLE_BIT]) begin
            res_one_now = one_s ^ one_ctrl_q[`CMP_ONE_INVERT_BIT];
        end
    end

    // One system clock stands in for the instruction cycle
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            res_one_q <= 1'b0;
        end else begin
            res_one_q <= res_one_now;
        end
    end

    always_comb begin
        res_two_next = res_two_q;
        if (!sync_sel_q) begin
            res_two_next = two_s;
        end else if (tclk_prev_q && !tclk_s) begin
            res_two_next = two_s;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            res_two_q <= 1'b0;
            tclk_prev_q <= 1'b0;
        end else begin
            res_two_q <= res_two_next;
            tclk_prev_q <= tclk_s;
        end
    end

    // ****************************************
    // Analog steering and pin drive
    // ****************************************
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_CMP_ONE_ENABLE <= 1'b0;
            O_CMP_ONE_CHANNEL_SELECT <= cmp_ctrl_pkg::CHAN_AN4;
            O_CMP_ONE_REF_SELECT <= 1'b0;
            O_CMP_ONE_SPEED <= 1'b0;
        end else begin
            O_CMP_ONE_ENABLE <= one_ctrl_q[`CMP_ONE_ENABLE_BIT];
            O_CMP_ONE_CHANNEL_SELECT <= one_ctrl_q[`CMP_ONE_CHAN_LSB+:2];
            O_CMP_ONE_REF_SELECT <= one_ctrl_q[`CMP_ONE_REF_BIT];
            O_CMP_ONE_SPEED <= one_ctrl_q[`CMP_ONE_SPEED_BIT];
        end
    end

    // Pin follows the unlatched result; the two synchroniser stages and the output flop are the only delay
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_CMP_ONE_PIN <= 1'b0;
            O_CMP_ONE_PIN_OE <= 1'b0;
            O_CMP_TWO_RESULT <= 1'b0;
        end else begin
            O_CMP_ONE_PIN <= res_one_now;
            O_CMP_ONE_PIN_OE <= one_ctrl_q[`CMP_ONE_PIN_EN_BIT];
            O_CMP_TWO_RESULT <= res_two_next;
        end
    end

    // ****************************************
    // Change flags and interrupt
    // ****************************************
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            prev_one_q <= 1'b0;
            prev_two_q <= 1'b0;
        end else begin
            prev_one_q <= res_one_q;
            prev_two_q <= res_two_q;
        end
    end

    // Pin enable is deliberately absent from the event terms
    assign change_ev = {res_two_q ^ prev_two_q, res_one_q ^ prev_one_q};

    // Read clears, but a same-cycle event survives
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            status_q <= 2'h0;
        end else begin
            status_q <= (rd_status ? 2'h0 : status_q) | change_ev;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(((rd_status ? 2'h0 : status_q) | change_ev) & mask_q);
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_HRDATA <= 32'h0;
        end else begin
            O_HRDATA <= 32'h0;
            if (I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
                case (I_HADDR[ADDR_W+1:2])
                    ADDR_W'(`CMP_IDX_ONE_CTRL): begin
                        O_HRDATA[7:0] <= one_ctrl_q;
                        O_HRDATA[`CMP_ONE_RESULT_BIT] <= res_one_q;
                    end
                    ADDR_W'(`CMP_IDX_TWO_AUX): begin
                        // Bits 5:1 stay zero
                        O_HRDATA[`CMP_MIRROR_ONE_BIT] <= res_one_q;
                        O_HRDATA[`CMP_MIRROR_TWO_BIT] <= res_two_q;
                        O_HRDATA[`CMP_TWO_SYNC_BIT] <= sync_sel_q;
                    end
                    ADDR_W'(`CMP_IDX_IRQ_STATUS): O_HRDATA[1:0] <= status_q;
                    ADDR_W'(`CMP_IDX_IRQ_MASK): O_HRDATA[1:0] <= mask_q;
                    default: O_HRDATA <= 32'h0;
                endcase
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_enable_gates;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        !one_ctrl_q[`CMP_ONE_ENABLE_BIT] |=> !res_one_q;
    endproperty
    a_enable_gates: assert property (p_enable_gates) else $error("Result set while disabled");

    property p_chan;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        1'b1 |=> O_CMP_ONE_CHANNEL_SELECT == $past(one_ctrl_q[1:0]);
    endproperty
    a_chan: assert property (p_chan) else $error("Channel select mismatch");

    property p_ref;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        1'b1 |=> O_CMP_ONE_REF_SELECT == $past(one_ctrl_q[`CMP_ONE_REF_BIT]);
    endproperty
    a_ref: assert property (p_ref) else $error("Reference select mismatch");

    property p_pin_oe;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        wr_ctrl ##1 1'b1 |=> O_CMP_ONE_PIN_OE == $past(I_HWDATA[`CMP_ONE_PIN_EN_BIT], 2);
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("Pin enable not applied");

    property p_polarity;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        one_ctrl_q[`CMP_ONE_ENABLE_BIT] |=> res_one_q == ($past(one_s) ^ $past(one_ctrl_q[`CMP_ONE_INVERT_BIT]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("Polarity wrong");

    property p_speed;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        1'b1 |=> O_CMP_ONE_SPEED == $past(one_ctrl_q[`CMP_ONE_SPEED_BIT]);
    endproperty
    a_speed: assert property (p_speed) else $error("Speed select mismatch");

    sequence s_fall_sync;
        sync_sel_q && !(tclk_prev_q && !tclk_s);
    endsequence
    property p_sync_hold;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        s_fall_sync |=> $stable(res_two_q);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("Sync output moved off edge");

    property p_flag_ro;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        1'b1 |-> !one_ctrl_q[`CMP_ONE_RESULT_BIT];
    endproperty
    a_flag_ro: assert property (p_flag_ro) else $error("Result flag stored from write");

    sequence s_change;
        res_one_q != prev_one_q;
    endsequence
    property p_sticky;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        s_change ##1 !rd_status |=> status_q[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("Change flag lost");
endmodule : cmp_ctrl
`default_nettype wire

// ### bench/cmp_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Analog cores and timer one clock source
// ****************************************
module cmp_far_side (
    input wire logic i_clk,
    input wire logic i_enable,
    input wire logic [1:0] i_channel,
    input wire logic i_ref_dac,
    input wire logic i_speed,
    input wire logic [3:0][7:0] i_chan_lvl,
    input wire logic [7:0] i_dac_lvl,
    input wire logic [7:0] i_ext_lvl,
    input wire logic i_two_high,
    input wire logic i_tmr_run,
    output logic o_one_raw,
    output logic o_two_raw,
    output logic o_tmr_clk
);
    logic [3:0] slow_q;
    logic [1:0] div_q;
    logic junk_q;
    logic above;
    initial begin
        slow_q = 4'h0;
        div_q = 2'h0;
        junk_q = 1'b0;
        o_one_raw = 1'b0;
        o_two_raw = 1'b0;
        o_tmr_clk = 1'b1;
    end
    assign above = (i_ref_dac ? i_dac_lvl : i_ext_lvl) > i_chan_lvl[i_channel];
    always @(posedge i_clk) begin
        junk_q <= ~junk_q;
        slow_q <= {slow_q[2:0], above};
        // A switched-off core gives no valid answer, so it toggles
        if (!i_enable) o_one_raw <= junk_q;
        else o_one_raw <= i_speed ? above : slow_q[3];
        o_two_raw <= i_two_high;
        // Timer clock stands still unless asked to run
        if (i_tmr_run) div_q <= div_q + 2'h1;
        if (i_tmr_run && div_q == 2'h3) o_tmr_clk <= ~o_tmr_clk;
    end
endmodule : cmp_far_side
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready, hresp, one_raw, two_raw, tmr_clk, en, rsel, spd, pin, pin_oe, two_res, irq;
    logic [1:0] ch;
    logic [3:0][7:0] lvl = {8'ha0, 8'h6e, 8'h3c, 8'h0a};
    logic [7:0] dac = 8'h55;
    logic [7:0] ext = 8'h87;
    logic two_high = 1'b0;
    logic tmr_run = 1'b0;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [7:0] wd;
    logic r;
    always #12.5 clk = ~clk;
    cmp_ctrl cmp_ctrl_i (.I_SYS_CLK(clk), .I_RESETN(resetn), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_CMP_ONE_RAW(one_raw),
        .I_CMP_TWO_RAW(two_raw), .I_TIMER_ONE_CLK(tmr_clk), .O_CMP_ONE_ENABLE(en),
        .O_CMP_ONE_CHANNEL_SELECT(ch), .O_CMP_ONE_REF_SELECT(rsel), .O_CMP_ONE_SPEED(spd),
        .O_CMP_ONE_PIN(pin), .O_CMP_ONE_PIN_OE(pin_oe), .O_CMP_TWO_RESULT(two_res), .O_IRQ(irq));
    cmp_far_side cmp_far_side_i (.i_clk(clk), .i_enable(en), .i_channel(ch), .i_ref_dac(rsel),
        .i_speed(spd), .i_chan_lvl(lvl), .i_dac_lvl(dac), .i_ext_lvl(ext), .i_two_high(two_high),
        .i_tmr_run(tmr_run), .o_one_raw(one_raw), .o_two_raw(two_raw), .o_tmr_clk(tmr_clk));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic exp_res(input logic [7:0] c);
        logic [7:0] vp;
        vp = c[2] ? dac : ext;
        return c[7] & ((vp > lvl[c[1:0]]) ^ c[4]);
    endfunction : exp_res
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdat);
        int n;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdat;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        rd = hrdata;
    endtask : xfer
    task automatic settle();
        repeat (14) @(posedge clk);
    endtask : settle
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            error_cnt++;
            complete_run();
        end
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        void'($urandom(48));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        // Two mapped registers and two unmapped holes, all zero out of reset
        for (int k = 0; k < 4; k++) begin
            xfer(1'b0, {20'h0, 12'h464 + 12'(k * 8)}, 32'h0);
            check(rd, 32'h0, "reset read");
        end
        check(hresp, 1'b0, "hresp");
        $display("test reset done");
        repeat (24) begin
            wd = 8'($urandom);
            lvl <= {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
            dac <= 8'($urandom);
            two_high <= 1'($urandom);
            xfer(1'b1, 32'h46c, {24'h0, 8'($urandom) & 8'hfe});
            // Pin enable only matters once the shared pin is freed by software
            xfer(1'b1, 32'h464, {24'h0, wd});
            settle();
            r = exp_res(wd);
            xfer(1'b0, 32'h464, 32'h0);
            check(rd, {24'h0, wd & 8'hbf | {1'b0, r, 6'h0}}, "ctrl");
            check({en, ch, rsel, spd, pin_oe}, {wd[7], wd[1:0], wd[2], wd[3], wd[5]}, "ctl pins");
            check(pin, r, "pin");
            xfer(1'b0, 32'h46c, 32'h0);
            check(rd, {24'h0, r, two_high, 6'h0}, "aux");
            check(two_res, two_high, "two async");
        end
        xfer(1'b1, 32'h46c, 32'hff);
        xfer(1'b0, 32'h46c, 32'h0);
        check(rd[5:0], 6'h01, "aux wr");
        $display("test fields done");
        lvl <= {8'ha0, 8'h6e, 8'h3c, 8'h0a};
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, 32'h484, {31'h0, k < 2});
            dac <= 8'h55;
            xfer(1'b1, 32'h464, {24'h0, 8'h85 | {2'h0, k[0], 5'h0}});
            settle();
            xfer(1'b0, 32'h480, 32'h0);
            dac <= 8'h20;
            settle();
            check(irq, k < 2, "irq");
            xfer(1'b0, 32'h480, 32'h0);
            check(rd, 32'h1, "status");
            xfer(1'b0, 32'h480, 32'h0);
            check({rd[0], irq}, 2'h0, "cleared");
        end
        $display("test irq done");
        xfer(1'b1, 32'h46c, 32'h01);
        xfer(1'b1, 32'h484, 32'h2);
        xfer(1'b0, 32'h480, 32'h0);
        r = two_res;
        two_high <= ~r;
        settle();
        check(two_res, r, "sync held");
        tmr_run <= 1'b1;
        repeat (2) settle();
        check(two_res, !r, "sync moved");
        tmr_run <= 1'b0;
        check(irq, 1'b1, "irq two");
        xfer(1'b0, 32'h480, 32'h0);
        check(rd[1], 1'b1, "status two");
        $display("test sync done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
